// [flash_read_param_pkg.sv]
// shared constants and state types for the read parameter command block
package flash_read_param_pkg;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_ENTER_SLEEP   = 8'hB9;
	localparam logic [7:0] OP_RELEASE_SLEEP = 8'hAB;
	localparam logic [7:0] OP_SET_RP_NV     = 8'h65;
	localparam logic [7:0] OP_SET_RP_V      = 8'h63;
	localparam logic [7:0] OP_SET_RP_V_ALT  = 8'hC0;
	localparam logic [7:0] OP_SET_EXT_NV    = 8'h85;
	localparam logic [7:0] OP_SET_EXT_V     = 8'h83;
	localparam logic [7:0] OP_RP_READBACK   = 8'h61;
	localparam logic [7:0] OP_EXT_READBACK  = 8'h81;
	localparam logic [7:0] OP_CLEAR_ERRORS  = 8'h82;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int RP_WRAP_BIT   = 2;
	localparam int RP_DUMMY_LSB  = 3;
	localparam int RP_PINSEL_BIT = 7;
	localparam int EXT_ERR_LSB   = 1;
	localparam int EXT_DRIVE_LSB = 5;
	localparam logic [7:0] RP_RESET       = 8'h00;
	localparam logic [7:0] EXT_RESET      = 8'hA0;
	localparam logic [7:0] EXT_DRIVE_MASK = 8'hE0;
	localparam logic [7:0] EXT_ERR_MASK   = 8'h0E;

	// ------------------------------------------------------------
	// timing and counts
	// ------------------------------------------------------------
	localparam int CLK_MHZ    = 125;
	localparam int T_RES1_NS  = 3000;
	localparam int RECOVER_W  = 9;
	localparam logic [RECOVER_W-1:0] RES1_COUNT =
		RECOVER_W'((T_RES1_NS * CLK_MHZ + 999) / 1000);
	localparam int ADDR_W     = 25;
	localparam logic [ADDR_W-1:0] BURST_BASE = 25'h0008;
	localparam logic [4:0] CNT_OP_DONE   = 5'h07;
	localparam logic [4:0] CNT_DATA_DONE = 5'h0F;
	localparam logic [4:0] CNT_MAX       = 5'h11;

	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef struct packed {
		logic                 blocked;
		logic [7:0]           rp;
		logic [7:0]           ext;
	} snapshot_t;

	typedef struct packed {
		logic                 csMeta;
		logic                 csSeen;
		logic                 csPrev;
		logic                 write_enable_latch;
		logic                 asleep;
		logic [RECOVER_W-1:0] recoverCnt;
		logic [7:0]           nvRp;
		logic [7:0]           vRp;
		logic [7:0]           nvExt;
		logic [7:0]           vExt;
		snapshot_t            shadow;
		logic [ADDR_W-1:0]    readAddr;
		logic                 readActive;
		logic                 tagSeen;
	} sysState_t;

	typedef struct packed {
		logic [4:0]           cnt;
		logic [7:0]           sh;
		logic [7:0]           op;
		logic [2:0]           bitPtr;
		logic [7:0]           outByte;
		logic                 reading;
		snapshot_t            copy;
	} linkState_t;

	typedef struct packed {
		logic                 valid;
		logic                 frameTag;
		logic [7:0]           op;
		logic [7:0]           data;
	} postState_t;

	typedef struct packed {
		logic                 sdo;
		logic                 oeN;
	} outState_t;

endpackage : flash_read_param_pkg

// [flash_read_param_cmds.sv]
// serial command interpreter for read parameter registers
//
// What this block does
// - asleep: every command except release is ignored
// - no command accepted until recovery time has run out
// - release ignored while an operation is in progress
// - read params: burst low, dummy count above, pin select top
// - top bit picks reset or hold use of shared pin
// - nonvolatile read param write needs write enable latch
// - volatile 63h write needs write enable latch
// - volatile C0h write needs no latch, leaves latch unchanged
// - nonvolatile write also loads the volatile copy
// - reset reloads volatile read params and drive field from nonvolatile
// - wrap off: read address climbs through whole array
// - wrap on: address wraps inside aligned burst window
// - values 0-3 linear, 4-7 bursts of 8,16,32,64 bytes
// - wrap holds until rewritten, power down or reset
// - burst read ends only when select goes high
// - extended register holds drive strength, default 50%
// - 85h writes nonvolatile and volatile, 83h volatile
// - 61h returns volatile read params
// - 81h returns volatile extended register
// - 82h clears the three error flags
// - error flags stay set until cleared by 82h
`timescale 1ns/1ns

module flash_read_param_cmds (
	input  wire logic                clk_sys,
	input  wire logic                resetn,
	input  wire logic                sck,
	input  wire logic                csN,
	input  wire logic                sdi,
	output logic                     sdo,
	output logic                     sdoOeN,
	input  wire logic                operationInProgressFlag,
	input  wire logic                softResetReq,
	input  wire logic [2:0]          errorSet,
	input  wire logic                readStart,
	input  wire logic [flash_read_param_pkg::ADDR_W-1:0] readStartAddr,
	input  wire logic                readAdvance,
	output logic [flash_read_param_pkg::ADDR_W-1:0] readAddr,
	output logic [7:0]               readParams,
	output logic [7:0]               extParams,
	output logic [2:0]               driveStrengthField,
	output logic                     sharedPinIsReset,
	output logic                     writeEnableLatch,
	output logic                     deepSleepState
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	flash_read_param_pkg::sysState_t  st;
	flash_read_param_pkg::sysState_t  st_next;
	flash_read_param_pkg::linkState_t lk;
	flash_read_param_pkg::linkState_t lk_next;
	flash_read_param_pkg::postState_t ps;
	flash_read_param_pkg::postState_t ps_next;
	flash_read_param_pkg::outState_t  os;
	flash_read_param_pkg::outState_t  os_next;

	logic                                  linkRst;
	logic                                  commit;
	logic                                  blocked;
	logic [7:0]                            byteIn;
	logic                                  opSingle;
	logic [flash_read_param_pkg::ADDR_W-1:0] burstMask;

	// frame reset: link shifter restarts on every select
	assign linkRst = csN | ~resetn;

	// ------------------------------------------------------------
	// link side: shifter on the serial clock
	// ------------------------------------------------------------
	assign byteIn = {lk.sh[6:0], sdi};

	always_comb begin
		opSingle = 1'b0;
		case (byteIn)
			flash_read_param_pkg::OP_WRITE_ENABLE,
			flash_read_param_pkg::OP_WRITE_DISABLE,
			flash_read_param_pkg::OP_ENTER_SLEEP,
			flash_read_param_pkg::OP_RELEASE_SLEEP,
			flash_read_param_pkg::OP_CLEAR_ERRORS: begin
				opSingle = 1'b1;
			end
			default: begin
			end
		endcase
	end

	always_comb begin
		lk_next = lk;
		ps_next = ps;
		if (lk.cnt != flash_read_param_pkg::CNT_MAX) begin
			lk_next.cnt = lk.cnt + 5'd1;
		end
		lk_next.sh = byteIn;
		if (lk.reading) begin
			lk_next.bitPtr = lk.bitPtr + 3'd1;
		end
		// snapshot frozen by sys side while select is low
		if (lk.cnt == 5'd0) begin
			lk_next.copy = st.shadow;
			ps_next.valid = 1'b0;
			ps_next.frameTag = ~ps.frameTag;
		end
		if (lk.cnt == flash_read_param_pkg::CNT_OP_DONE) begin
			lk_next.op = byteIn;
			ps_next.op = byteIn;
			ps_next.valid = opSingle;
			if (byteIn == flash_read_param_pkg::OP_RP_READBACK) begin
				lk_next.outByte = lk.copy.rp;
				lk_next.reading = ~lk.copy.blocked;
			end
			if (byteIn == flash_read_param_pkg::OP_EXT_READBACK) begin
				lk_next.outByte = lk.copy.ext;
				lk_next.reading = ~lk.copy.blocked;
			end
		end
		if (lk.cnt == 5'd8) begin
			// any bit past the opcode spoils a one-byte command
			ps_next.valid = 1'b0;
		end
		if (lk.cnt == flash_read_param_pkg::CNT_DATA_DONE) begin
			case (lk.op)
				flash_read_param_pkg::OP_SET_RP_NV,
				flash_read_param_pkg::OP_SET_RP_V,
				flash_read_param_pkg::OP_SET_RP_V_ALT,
				flash_read_param_pkg::OP_SET_EXT_NV,
				flash_read_param_pkg::OP_SET_EXT_V: begin
					ps_next.data  = byteIn;
					ps_next.valid = 1'b1;
				end
				default: begin
				end
			endcase
		end
		if (lk.cnt == 5'd16) begin
			ps_next.valid = 1'b0;
		end
		os_next.sdo = lk.outByte[3'd7 - lk.bitPtr];
		os_next.oeN = ~lk.reading;
	end

	always_ff @(posedge sck or posedge linkRst) begin
		if (linkRst) begin
			lk <= '0;
		end else begin
			lk <= lk_next;
		end
	end

	// posted command outlives the frame; sys reads it after deselect
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			ps <= '0;
		end else begin
			ps <= ps_next;
		end
	end

	// drive out on the falling edge so a rising-edge host samples safely
	always_ff @(negedge sck or posedge linkRst) begin
		if (linkRst) begin
			os <= 2'b01;
		end else begin
			os <= os_next;
		end
	end

	// ------------------------------------------------------------
	// system side: registers and sequencing
	// ------------------------------------------------------------
	assign blocked = st.asleep | (st.recoverCnt != '0);
	// posted word is stable: serial clock stops while select is high
	assign commit = st.csSeen & ~st.csPrev & ps.valid
		& (ps.frameTag != st.tagSeen);
	assign burstMask = (flash_read_param_pkg::BURST_BASE
		<< st.vRp[1:0]) - 25'h0001;

	function automatic logic [flash_read_param_pkg::ADDR_W-1:0] nextAddr(
		input logic [flash_read_param_pkg::ADDR_W-1:0] addr,
		input logic [flash_read_param_pkg::ADDR_W-1:0] mask,
		input logic                                    wrap
	);
		logic [flash_read_param_pkg::ADDR_W-1:0] inc;
		inc = addr + 25'h0001;
		if (wrap) begin
			nextAddr = (addr & ~mask) | (inc & mask);
		end else begin
			nextAddr = inc;
		end
	endfunction : nextAddr

	always_comb begin
		st_next = st;
		st_next.csMeta = csN;
		st_next.csSeen = st.csMeta;
		st_next.csPrev = st.csSeen;
		if (st.csSeen && !st.csPrev) begin
			st_next.tagSeen = ps.frameTag;
		end
		if (st.recoverCnt != '0) begin
			st_next.recoverCnt = st.recoverCnt - 9'd1;
		end
		if (st.csSeen) begin
			st_next.shadow = {blocked, st.vRp, st.vExt};
		end
		if (commit && !blocked) begin
			case (ps.op)
				flash_read_param_pkg::OP_WRITE_ENABLE: begin
					st_next.write_enable_latch = 1'b1;
				end
				flash_read_param_pkg::OP_WRITE_DISABLE: begin
					st_next.write_enable_latch = 1'b0;
				end
				flash_read_param_pkg::OP_ENTER_SLEEP: begin
					st_next.asleep = 1'b1;
					st_next.vRp = st.nvRp;
				end
				flash_read_param_pkg::OP_SET_RP_NV: begin
					if (st.write_enable_latch) begin
						st_next.nvRp = ps.data;
						st_next.vRp = ps.data;
						st_next.write_enable_latch = 1'b0;
					end
				end
				flash_read_param_pkg::OP_SET_RP_V: begin
					if (st.write_enable_latch) begin
						st_next.vRp = ps.data;
						st_next.write_enable_latch = 1'b0;
					end
				end
				flash_read_param_pkg::OP_SET_RP_V_ALT: begin
					st_next.vRp = ps.data;
				end
				flash_read_param_pkg::OP_SET_EXT_NV: begin
					if (st.write_enable_latch) begin
						st_next.nvExt = (st.nvExt
							& ~flash_read_param_pkg::EXT_DRIVE_MASK)
							| (ps.data
							& flash_read_param_pkg::EXT_DRIVE_MASK);
						st_next.vExt = (st.vExt
							& ~flash_read_param_pkg::EXT_DRIVE_MASK)
							| (ps.data
							& flash_read_param_pkg::EXT_DRIVE_MASK);
						st_next.write_enable_latch = 1'b0;
					end
				end
				flash_read_param_pkg::OP_SET_EXT_V: begin
					st_next.vExt = (st.vExt
						& ~flash_read_param_pkg::EXT_DRIVE_MASK)
						| (ps.data
						& flash_read_param_pkg::EXT_DRIVE_MASK);
				end
				flash_read_param_pkg::OP_CLEAR_ERRORS: begin
					st_next.vExt = st.vExt
						& ~flash_read_param_pkg::EXT_ERR_MASK;
				end
				default: begin
				end
			endcase
		end else if (commit && st.asleep && !operationInProgressFlag
			&& ps.op == flash_read_param_pkg::OP_RELEASE_SLEEP) begin
			st_next.asleep = 1'b0;
			st_next.recoverCnt = flash_read_param_pkg::RES1_COUNT;
		end
		if (softResetReq) begin
			st_next.vRp = st.nvRp;
			st_next.vExt = (st.vExt & ~flash_read_param_pkg::EXT_DRIVE_MASK)
				| (st.nvExt & flash_read_param_pkg::EXT_DRIVE_MASK);
			st_next.write_enable_latch = 1'b0;
		end
		// set wins over a clear in the same cycle
		st_next.vExt[flash_read_param_pkg::EXT_ERR_LSB +: 3] =
			st_next.vExt[flash_read_param_pkg::EXT_ERR_LSB +: 3]
			| errorSet;
		if (readStart) begin
			st_next.readAddr = readStartAddr;
			st_next.readActive = 1'b1;
		end else if (readAdvance && st.readActive) begin
			st_next.readAddr = nextAddr(st.readAddr, burstMask,
				st.vRp[flash_read_param_pkg::RP_WRAP_BIT]);
		end
		if (st.csSeen) begin
			st_next.readActive = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
			st.csMeta <= 1'b1;
			st.csSeen <= 1'b1;
			st.csPrev <= 1'b1;
			st.nvRp <= flash_read_param_pkg::RP_RESET;
			st.vRp <= flash_read_param_pkg::RP_RESET;
			st.nvExt <= flash_read_param_pkg::EXT_RESET;
			st.vExt <= flash_read_param_pkg::EXT_RESET;
			st.shadow <= {1'b0, flash_read_param_pkg::RP_RESET,
				flash_read_param_pkg::EXT_RESET};
		end else begin
			st <= st_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sdo = os.sdo;
	assign sdoOeN = os.oeN;
	assign readAddr = st.readAddr;
	assign readParams = st.vRp;
	assign extParams = st.vExt;
	assign driveStrengthField =
		st.vExt[flash_read_param_pkg::EXT_DRIVE_LSB +: 3];
	// dedicated reset pin is resetn and ignores this bit
	assign sharedPinIsReset =
		st.vRp[flash_read_param_pkg::RP_PINSEL_BIT];
	assign writeEnableLatch = st.write_enable_latch;
	assign deepSleepState = st.asleep;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sleep_ignore_a: assert property (
		st.asleep && commit
		&& ps.op != flash_read_param_pkg::OP_RELEASE_SLEEP
		|=> st.asleep && $stable(st.vRp) && $stable(st.write_enable_latch))
		else $error("command acted while asleep");
	recovery_start_a: assert property (
		st.asleep && commit && !operationInProgressFlag
		&& ps.op == flash_read_param_pkg::OP_RELEASE_SLEEP
		|=> !st.asleep
		&& st.recoverCnt == flash_read_param_pkg::RES1_COUNT)
		else $error("release did not start recovery");
	recovery_block_a: assert property (
		commit && st.recoverCnt != '0
		|=> $stable(st.vRp) && $stable(st.write_enable_latch) && $stable(st.nvRp))
		else $error("command taken during recovery");
	busy_release_a: assert property (
		st.asleep && commit && operationInProgressFlag
		|=> st.asleep && st.recoverCnt == '0)
		else $error("release taken while busy");
	nv_needs_wel_a: assert property (
		commit && !st.write_enable_latch && !softResetReq
		&& ps.op == flash_read_param_pkg::OP_SET_RP_NV
		|=> $stable(st.nvRp) && $stable(st.vRp))
		else $error("nonvolatile write without latch");
	v_needs_wel_a: assert property (
		commit && !st.write_enable_latch && !softResetReq
		&& ps.op == flash_read_param_pkg::OP_SET_RP_V
		|=> $stable(st.vRp))
		else $error("volatile write without latch");
	alt_write_a: assert property (
		commit && !blocked && !softResetReq
		&& ps.op == flash_read_param_pkg::OP_SET_RP_V_ALT
		|=> st.vRp == $past(ps.data) && st.write_enable_latch == $past(st.write_enable_latch))
		else $error("alternate volatile write wrong");
	nv_mirror_a: assert property (
		commit && st.write_enable_latch && !blocked && !softResetReq
		&& ps.op == flash_read_param_pkg::OP_SET_RP_NV
		|=> st.vRp == st.nvRp && st.nvRp == $past(ps.data) && !st.write_enable_latch)
		else $error("volatile copy not mirrored");
	linear_addr_a: assert property (
		st.readActive && readAdvance && !readStart && !st.csSeen
		&& !st.vRp[flash_read_param_pkg::RP_WRAP_BIT]
		|=> st.readAddr == $past(st.readAddr) + 25'h0001)
		else $error("linear read address not incremented");
	wrap_addr_a: assert property (
		st.readActive && readAdvance && !readStart
		&& st.vRp[flash_read_param_pkg::RP_WRAP_BIT]
		|=> ((st.readAddr ^ $past(st.readAddr)) & ~$past(burstMask)) == '0
		&& (st.readAddr & $past(burstMask))
		== (($past(st.readAddr) + 25'h0001) & $past(burstMask)))
		else $error("wrapped address left burst window");
	burst_end_a: assert property (
		st.csSeen && !readStart |=> !st.readActive)
		else $error("burst outlived the frame");
	error_sticky_a: assert property (
		st.vExt[flash_read_param_pkg::EXT_ERR_LSB]
		&& !(commit && ps.op == flash_read_param_pkg::OP_CLEAR_ERRORS)
		|=> st.vExt[flash_read_param_pkg::EXT_ERR_LSB])
		else $error("error flag dropped without clear");
	error_clear_a: assert property (
		commit && !blocked && errorSet == 3'b000
		&& ps.op == flash_read_param_pkg::OP_CLEAR_ERRORS
		|=> (st.vExt & flash_read_param_pkg::EXT_ERR_MASK) == 8'h00)
		else $error("clear did not zero error flags");

endmodule : flash_read_param_cmds

// [flash_read_param_cmds_end.sv]
// holds no logic of its own

// [flash_host_model.sv]
// behavioural host controller driving the serial link of the device
`timescale 1ns/1ns

module flash_host_model (
	output logic      sck,
	output logic      csN,
	output logic      sdi,
	input  wire logic sdo,
	input  wire logic sdoOeN
);
	// ------------------------------------------------------------
	// idle levels
	// ------------------------------------------------------------
	// link clock stands low between frames, mode 0
	initial begin
		sck = 1'b0;
		csN = 1'b1;
		sdi = 1'b0;
	end

	// ------------------------------------------------------------
	// frames
	// ------------------------------------------------------------
	// opcode in the top byte, data byte right after it
	task automatic frame(input logic [15:0] bits, input int n,
		output logic [7:0] rd);
		rd = 8'hxx;
		csN = 1'b0;
		#30;
		for (int i = 0; i < n; i++) begin
			sdi = bits[15-i];
			#3 sck = 1'b1;
			if (i >= 8)
				rd[15-i] = (sdoOeN === 1'b0) ? sdo : 1'bx;
			#3 sck = 1'b0;
		end
		#6 csN = 1'b1;
		// released line shows no stale value
		sdi = ~sdi;
	endtask : frame

	// select without clocks, used to hold a read burst open
	task automatic sel(input logic lvl);
		csN = lvl;
	endtask : sel
endmodule : flash_host_model

// [test_flash_read_param_cmds.sv]
// self-checking testbench for the read parameter command block
`timescale 1ns/1ns

module test_flash_read_param_cmds;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic        sck, csN, sdi, sdo, sdoOeN;
	logic        operationInProgressFlag = 1'b0;
	logic        softResetReq = 1'b0;
	logic [2:0]  errorSet = 3'h0;
	logic        readStart = 1'b0;
	logic [24:0] readStartAddr = 25'h0;
	logic        readAdvance = 1'b0;
	logic [24:0] readAddr;
	logic [7:0]  readParams, extParams, rd;
	logic [2:0]  driveStrengthField;
	logic        sharedPinIsReset, writeEnableLatch, deepSleepState;
	int          n_fail = 0;
	int          total_checks = 0;

	always #4 clk_sys = ~clk_sys;

	flash_read_param_cmds flash_read_param_cmds_i (
		.clk_sys(clk_sys), .resetn(resetn), .sck(sck), .csN(csN),
		.sdi(sdi), .sdo(sdo), .sdoOeN(sdoOeN),
		.operationInProgressFlag(operationInProgressFlag),
		.softResetReq(softResetReq), .errorSet(errorSet),
		.readStart(readStart), .readStartAddr(readStartAddr),
		.readAdvance(readAdvance), .readAddr(readAddr),
		.readParams(readParams), .extParams(extParams),
		.driveStrengthField(driveStrengthField),
		.sharedPinIsReset(sharedPinIsReset),
		.writeEnableLatch(writeEnableLatch),
		.deepSleepState(deepSleepState)
	);

	flash_host_model flash_host_model_i (
		.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOeN(sdoOeN)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(string name, logic [24:0] seen, logic [24:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	task automatic sys(int n);
		repeat (n) @(negedge clk_sys);
	endtask : sys

	// commit lands 3 edges after deselect, 6 leaves margin
	task automatic cmd1(logic [7:0] op);
		flash_host_model_i.frame({op, 8'h00}, 8, rd);
		sys(6);
	endtask : cmd1

	task automatic cmd2(logic [7:0] op, logic [7:0] d);
		flash_host_model_i.frame({op, d}, 16, rd);
		sys(6);
	endtask : cmd2

	task automatic rdback(logic [7:0] op);
		flash_host_model_i.frame({op, 8'h00}, 16, rd);
		sys(6);
	endtask : rdback

	function automatic logic [24:0] nxt(logic [24:0] a, logic [2:0] c);
		logic [24:0] m;
		m = (25'h8 << c[1:0]) - 25'h1;
		if (c[2])
			return (a & ~m) | ((a + 25'h1) & m);
		return a + 25'h1;
	endfunction : nxt

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check("rp", readParams, 8'h00);
		check("ext", extParams, 8'hA0);
		check("drive", driveStrengthField, 3'h5);
		check("wel", writeEnableLatch, 1'b0);
		check("sleep", deepSleepState, 1'b0);
		check("oe", sdoOeN, 1'b1);
	endtask : t_reset

	task automatic t_params();
		cmd2(flash_read_param_pkg::OP_SET_RP_V, 8'h55);
		check("rp", readParams, 8'h00);
		cmd2(flash_read_param_pkg::OP_SET_RP_NV, 8'h55);
		check("rp", readParams, 8'h00);
		cmd2(flash_read_param_pkg::OP_SET_RP_V_ALT, 8'hD3);
		check("rp", readParams, 8'hD3);
		check("wel", writeEnableLatch, 1'b0);
		check("dummy", readParams[6:3], 4'hA);
		check("pin", sharedPinIsReset, 1'b1);
		cmd1(flash_read_param_pkg::OP_WRITE_ENABLE);
		check("wel", writeEnableLatch, 1'b1);
		cmd2(flash_read_param_pkg::OP_SET_RP_V, 8'h8C);
		check("rp", readParams, 8'h8C);
		rdback(flash_read_param_pkg::OP_RP_READBACK);
		check("rd", rd, 8'h8C);
		cmd1(flash_read_param_pkg::OP_WRITE_ENABLE);
		cmd2(flash_read_param_pkg::OP_SET_RP_NV, 8'h06);
		check("rp", readParams, 8'h06);
		cmd2(flash_read_param_pkg::OP_SET_RP_V_ALT, 8'h40);
		rdback(flash_read_param_pkg::OP_RP_READBACK);
		check("rd", rd, 8'h40);
		// opcode without its data byte must be dropped
		cmd1(flash_read_param_pkg::OP_SET_RP_V_ALT);
		check("rp", readParams, 8'h40);
		softResetReq = 1'b1;
		sys(1);
		softResetReq = 1'b0;
		sys(2);
		check("rp", readParams, 8'h06);
	endtask : t_params

	task automatic t_wrap();
		logic [24:0] exp;
		for (int c = 0; c < 8; c++) begin
			cmd2(flash_read_param_pkg::OP_SET_RP_V_ALT, 8'(c));
			flash_host_model_i.sel(1'b0);
			sys(4);
			// start near the top of the array to see the roll-over
			readStart = 1'b1;
			readStartAddr = 25'h1FF_FFFE;
			sys(1);
			readStart = 1'b0;
			exp = 25'h1FF_FFFE;
			check("addr", readAddr, exp);
			readAdvance = 1'b1;
			for (int k = 0; k < 10; k++) begin
				sys(1);
				exp = nxt(exp, 3'(c));
				check("addr", readAddr, exp);
			end
			readAdvance = 1'b0;
			flash_host_model_i.sel(1'b1);
			sys(6);
			readAdvance = 1'b1;
			sys(1);
			readAdvance = 1'b0;
			sys(1);
			check("addr", readAddr, exp);
		end
	endtask : t_wrap

	task automatic t_ext();
		cmd2(flash_read_param_pkg::OP_SET_EXT_V, 8'h40);
		check("ext", extParams, 8'h40);
		cmd2(flash_read_param_pkg::OP_SET_EXT_NV, 8'h20);
		check("ext", extParams, 8'h40);
		cmd1(flash_read_param_pkg::OP_WRITE_ENABLE);
		cmd2(flash_read_param_pkg::OP_SET_EXT_NV, 8'h20);
		check("drive", driveStrengthField, 3'h1);
		rdback(flash_read_param_pkg::OP_EXT_READBACK);
		check("rd", rd, 8'h20);
		errorSet = 3'h7;
		sys(1);
		errorSet = 3'h0;
		sys(2);
		check("ext", extParams, 8'h2E);
		cmd2(flash_read_param_pkg::OP_SET_EXT_V, 8'hE0);
		check("ext", extParams, 8'hEE);
		cmd1(flash_read_param_pkg::OP_CLEAR_ERRORS);
		check("ext", extParams, 8'hE0);
		errorSet = 3'h2;
		sys(1);
		errorSet = 3'h0;
		// a select with no clocks must not replay the clear
		flash_host_model_i.sel(1'b0);
		sys(4);
		flash_host_model_i.sel(1'b1);
		sys(6);
		check("ext", extParams, 8'hE4);
	endtask : t_ext

	task automatic t_sleep();
		cmd2(flash_read_param_pkg::OP_SET_RP_V_ALT, 8'h07);
		cmd1(flash_read_param_pkg::OP_ENTER_SLEEP);
		check("sleep", deepSleepState, 1'b1);
		check("rp", readParams, 8'h06);
		cmd2(flash_read_param_pkg::OP_SET_RP_V_ALT, 8'h33);
		check("rp", readParams, 8'h06);
		rdback(flash_read_param_pkg::OP_RP_READBACK);
		check("rd", rd, 8'hxx);
		operationInProgressFlag = 1'b1;
		cmd1(flash_read_param_pkg::OP_RELEASE_SLEEP);
		check("sleep", deepSleepState, 1'b1);
		operationInProgressFlag = 1'b0;
		cmd1(flash_read_param_pkg::OP_RELEASE_SLEEP);
		check("sleep", deepSleepState, 1'b0);
		// early command on purpose, inside the recovery time
		sys(20);
		cmd2(flash_read_param_pkg::OP_SET_RP_V_ALT, 8'h33);
		check("rp", readParams, 8'h06);
		sys(400);
		cmd2(flash_read_param_pkg::OP_SET_RP_V_ALT, 8'h33);
		check("rp", readParams, 8'h33);
	endtask : t_sleep

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		sys(2);
		resetn = 1'b1;
		sys(3);
		t_reset();
		t_params();
		t_wrap();
		t_ext();
		t_sleep();
		final_report();
	end

	// whole run needs roughly 11 us
	initial begin
		#100000;
		n_fail++;
		final_report();
	end
endmodule : test_flash_read_param_cmds
